// ### verification/awc_chk.sv
// concurrent checks on the add datapath bus and execution pulse
`timescale 1ns/1ps
`default_nettype none
module awc_chk (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire exec_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // handshake: one wait cycle, one answer cycle, high when idle
    a_wait_after_req: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    a_wait_one_low: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
    a_wait_idle_high: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest) else $error("answer without request");
    // instruction execution pulse tied to a taken instruction write
    a_exec_follows: assert property (
        avs_write && !avs_waitrequest && avs_address == 8'h00 |=> exec_pulse)
        else $error("no pulse after instruction");
    a_exec_has_cause: assert property (
        exec_pulse |-> $past(avs_write) && !$past(avs_waitrequest) && $past(avs_address) == 8'h00)
        else $error("pulse without instruction");
    a_exec_single: assert property (
        exec_pulse |=> !exec_pulse) else $error("pulse too long");
    // read data only change on a read
    a_rdata_hold: assert property (
        !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
    a_instr_reads_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h00 |-> avs_readdata == 32'h0)
        else $error("instruction slot not zero");
endmodule

bind awc_datapath awc_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_pulse(exec_pulse));
`default_nettype wire

// ### verification/awc_tb.sv
// self-checking bench for the add datapath
`timescale 1ns/1ps
`default_nettype none
`include "awc_consts.vh"
module testbench;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, exec_pulse;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_val, m_pc, m_cur, m_sav;
    logic [31:0] m_gpr [0:14];
    int miscompares = 0;
    int check_count = 0;
    awc_datapath u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_pulse(exec_pulse));
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // verdict and end of run
    task final_report;
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    // bus master: hold request until waitrequest sampled low
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        avs_read <= 1'b0;
        check(rd_val, exp);
    endtask
    task set_gpr(input logic [3:0] n, input logic [31:0] v);
        m_gpr[n] = v;
        bus_wr(`AWC_OFF_GPR_BASE + {2'b00, n, 2'b00}, v);
    endtask
    // executes one word and compares destination, status and execution status
    task run(input logic [3:0] cond, opc, input logic s, i, input logic [3:0] rn, rd,
             input logic [11:0] fld, input logic [31:0] b);
        logic [32:0] sum;
        logic [31:0] a, res;
        logic pass, nadd, rst, unp;
        a = (rn == 4'hF) ? m_pc + `AWC_PC_OFFSET : m_gpr[rn];
        sum = a + b + ((opc == `AWC_OPC_ADC) ? m_cur[`AWC_FLAG_C] : 1'b0);
        res = sum[31:0];
        pass = cond == `AWC_COND_ALWAYS || (cond == 4'h0 && m_cur[`AWC_FLAG_Z]);
        nadd = !i && fld[7] && fld[4];
        rst = pass && !nadd && s && rd == 4'hF;
        unp = rst && (m_cur[4:0] == `AWC_MODE_USER || m_cur[4:0] == `AWC_MODE_SYSTEM);
        bus_wr(`AWC_OFF_INSTR, {cond, 2'b00, i, opc, s, rn, rd, fld});
        if (pass && !nadd) begin
            if (rd == 4'hF)
                m_pc = res;
            else
                m_gpr[rd] = res;
            if (rst && !unp)
                m_cur = m_sav;
            else if (s && !rst)
                m_cur[31:28] = {res[31], res == 0, sum[32], a[31] == b[31] && res[31] != a[31]};
        end
        if (rd == 4'hF)
            rd_chk(`AWC_OFF_PC, m_pc);
        else
            rd_chk(`AWC_OFF_GPR_BASE + {2'b00, rd, 2'b00}, m_gpr[rd]);
        rd_chk(`AWC_OFF_CUR_STATUS, m_cur);
        bus_wr(`AWC_OFF_GPR_LAST, m_gpr[14]);
        rd_chk(`AWC_OFF_EXEC_STATUS, {27'h0, rst, unp, nadd, !pass && !nadd, 1'b1});
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        m_pc = 32'h0;
        m_cur = `AWC_RST_CUR_STATUS;
        m_sav = 32'h0;
        for (int k = 0; k < 15; k++)
            m_gpr[k] = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`AWC_OFF_CUR_STATUS, `AWC_RST_CUR_STATUS);
        rd_chk(`AWC_OFF_INSTR, 32'h0);
        set_gpr(1, 32'h7FFFFFFF);
        set_gpr(2, 32'h00000001);
        set_gpr(8, 32'hFFFFFFFF);
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 1, 0, 1, 3, 12'h002, 32'h1);
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 1, 1, 8, 4, 12'h001, 32'h1);
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADC, 0, 1, 2, 5, 12'h4FF, 32'hFF000000);
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADC, 1, 0, 1, 6, 12'h202, 32'h10);
        run(4'h0, `AWC_OPC_ADD, 0, 1, 1, 7, 12'h005, 32'h5);
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 0, 0, 1, 7, 12'h092, 32'h0);
        bus_wr(`AWC_OFF_PC, 32'h100);
        m_pc = 32'h100;
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 0, 1, 15, 9, 12'h000, 32'h0);
        bus_wr(`AWC_OFF_SAVED_STATUS, 32'hA0000011);
        m_sav = 32'hA0000011;
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 1, 1, 2, 15, 12'h040, 32'h40);
        bus_wr(`AWC_OFF_CUR_STATUS, 32'h00000010);
        m_cur = 32'h00000010;
        run(`AWC_COND_ALWAYS, `AWC_OPC_ADD, 1, 1, 2, 15, 12'h000, 32'h0);
        bus_wr(8'h20, 32'h12345678);
        rd_chk(8'h20, 32'h0);
        final_report;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire

// ### verilog/awc_consts.vh
// constants of the add-with-carry datapath and its register map
// Behaviour
// - add with carry writes first operand plus second operand plus carry flag
// - plain add writes first operand plus second operand, no carry input
// - flag-update bit 20 clear leaves the whole current status register unchanged
// - flags set, destination not 15: negative is result bit 31, zero when result zero
// - carry shows unsigned overflow, overflow shows signed overflow, carry-in included
// - all other current status bits keep their previous value
// - flags set, destination 15: saved status copied into current status
// - status copy in user or system mode is unpredictable; any behaviour allowed
// - bit 25 and bits 11:0 choose immediate or optionally shifted register operand
// - bit 25 clear with operand bits 7 and 4 set is not an add
// - both take effect only when condition passes; always condition by default
// - neither addition raises its own exception
// - program counter read as operand gives instruction address plus eight
`ifndef AWC_CONSTS_VH
`define AWC_CONSTS_VH

// register byte offsets
`define AWC_OFF_INSTR 8'h00
`define AWC_OFF_PC 8'h04
`define AWC_OFF_CUR_STATUS 8'h08
`define AWC_OFF_SAVED_STATUS 8'h0C
`define AWC_OFF_EXEC_STATUS 8'h10
`define AWC_OFF_GPR_BASE 8'h40
`define AWC_OFF_GPR_LAST 8'h78

// instruction field positions and encodings
`define AWC_BIT_S 20
`define AWC_BIT_I 25
`define AWC_BIT_SH7 7
`define AWC_BIT_SH4 4
`define AWC_OPC_ADC 4'h5
`define AWC_OPC_ADD 4'h4
`define AWC_COND_ALWAYS 4'hE

// status register flag positions
`define AWC_FLAG_N 31
`define AWC_FLAG_Z 30
`define AWC_FLAG_C 29
`define AWC_FLAG_V 28

// modes without a saved status register
`define AWC_MODE_USER 5'h10
`define AWC_MODE_SYSTEM 5'h1F

// reset values and program counter read offset
`define AWC_RST_CUR_STATUS 32'h000000D3
`define AWC_RST_WORD 32'h00000000
`define AWC_PC_OFFSET 32'h00000008

// execution status bits
`define AWC_EX_DONE 0
`define AWC_EX_CONDFAIL 1
`define AWC_EX_NOTADD 2
`define AWC_EX_UNPRED 3
`define AWC_EX_RESTORE 4

`endif

// ### verilog/awc_datapath.v
// add and add-with-carry execution datapath with avalon-mm register access
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "awc_consts.vh"

module awc_datapath (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg exec_pulse
);

    // architectural state
    reg [31:0] gpr_reg [0:14];
    reg [31:0] pc_reg;
    reg [31:0] current_status_reg;
    reg [31:0] saved_status_reg;
    reg [4:0] exec_status_reg;
    reg [31:0] rdata_next;
    integer i;

    // condition check against current flags
    function cond_pass;
        input [3:0] cond;
        input [3:0] nzcv;
        reg n, z, c, v;
        begin
            n = nzcv[3];
            z = nzcv[2];
            c = nzcv[1];
            v = nzcv[0];
            case (cond)
                4'h0: cond_pass = z;
                4'h1: cond_pass = ~z;
                4'h2: cond_pass = c;
                4'h3: cond_pass = ~c;
                4'h4: cond_pass = n;
                4'h5: cond_pass = ~n;
                4'h6: cond_pass = v;
                4'h7: cond_pass = ~v;
                4'h8: cond_pass = c & ~z;
                4'h9: cond_pass = ~c | z;
                4'hA: cond_pass = (n == v);
                4'hB: cond_pass = (n != v);
                4'hC: cond_pass = ~z & (n == v);
                4'hD: cond_pass = z | (n != v);
                4'hE: cond_pass = 1'b1;
                default: cond_pass = 1'b0;
            endcase
        end
    endfunction

    // second operand: rotated immediate or shifted register
    function [31:0] shift_op;
        input [11:0] fld;
        input imm_sel;
        input [31:0] rm;
        input [31:0] rs;
        input cin;
        reg [63:0] dbl;
        reg [7:0] amt;
        reg by_reg;
        begin
            dbl = 64'h0;
            amt = 8'h00;
            by_reg = fld[`AWC_BIT_SH4];
            shift_op = rm;
            if (imm_sel) begin
                dbl = {24'h000000, fld[7:0], 24'h000000, fld[7:0]} >> {fld[11:8], 1'b0};
                shift_op = dbl[31:0];
            end else begin
                amt = by_reg ? rs[7:0] : {3'b000, fld[11:7]};
                case (fld[6:5])
                    2'b00: begin
                        if (amt >= 8'h20)
                            shift_op = 32'h00000000;
                        else
                            shift_op = rm << amt[4:0];
                    end
                    2'b01: begin
                        if (amt == 8'h00 && by_reg)
                            shift_op = rm;
                        else if (amt == 8'h00 || amt >= 8'h20)
                            shift_op = 32'h00000000; // immediate zero means 32
                        else
                            shift_op = rm >> amt[4:0];
                    end
                    2'b10: begin
                        if (amt == 8'h00 && by_reg)
                            shift_op = rm;
                        else if (amt == 8'h00 || amt >= 8'h20)
                            shift_op = {32{rm[31]}};
                        else
                            shift_op = $signed(rm) >>> amt[4:0];
                    end
                    default: begin
                        if (amt == 8'h00 && !by_reg) begin
                            shift_op = {cin, rm[31:1]}; // rotate through carry
                        end else begin
                            dbl = {rm, rm} >> amt[4:0];
                            shift_op = dbl[31:0];
                        end
                    end
                endcase
            end
        end
    endfunction

    // operand read, program counter seen eight bytes ahead
    function [31:0] read_gpr;
        input [3:0] idx;
        input [31:0] r14_to_0_val;
        input [31:0] pc_val;
        begin
            if (idx == 4'hF)
                read_gpr = pc_val + `AWC_PC_OFFSET;
            else
                read_gpr = r14_to_0_val;
        end
    endfunction

    // decode of the instruction word being written
    wire [31:0] iw = avs_writedata;
    wire [3:0] rn_idx = iw[19:16];
    wire [3:0] rd_idx = iw[15:12];
    wire [3:0] rm_idx = iw[3:0];
    wire [3:0] rs_idx = iw[11:8];
    wire [31:0] rn_val = read_gpr(rn_idx, gpr_reg[rn_idx[3:0] == 4'hF ? 4'h0 : rn_idx], pc_reg);
    wire [31:0] rm_val = read_gpr(rm_idx, gpr_reg[rm_idx == 4'hF ? 4'h0 : rm_idx], pc_reg);
    wire [31:0] rs_val = read_gpr(rs_idx, gpr_reg[rs_idx == 4'hF ? 4'h0 : rs_idx], pc_reg);
    wire cflag = current_status_reg[`AWC_FLAG_C];

    wire is_adc = (iw[27:26] == 2'b00) && (iw[24:21] == `AWC_OPC_ADC);
    wire is_add = (iw[27:26] == 2'b00) && (iw[24:21] == `AWC_OPC_ADD);
    wire ext_space = !iw[`AWC_BIT_I] && iw[`AWC_BIT_SH7] && iw[`AWC_BIT_SH4];
    wire is_sum = (is_adc || is_add) && !ext_space;
    wire passed = cond_pass(iw[31:28], current_status_reg[31:28]);

    wire [31:0] op2 = shift_op(iw[11:0], iw[`AWC_BIT_I], rm_val, rs_val, cflag);
    wire cin = is_adc ? cflag : 1'b0;
    wire [32:0] sum33 = {1'b0, rn_val} + {1'b0, op2} + {32'h00000000, cin};
    wire [31:0] result = sum33[31:0];
    wire c_out = sum33[32];
    wire v_out = (rn_val[31] == op2[31]) && (result[31] != rn_val[31]);

    // status-restoring form and its unpredictable modes
    wire [4:0] cur_mode = current_status_reg[4:0];
    wire no_saved = (cur_mode == `AWC_MODE_USER) || (cur_mode == `AWC_MODE_SYSTEM);

    // bus handshake: one wait cycle, then transfer
    wire req = avs_read || avs_write;
    wire xfer = req && !avs_waitrequest;
    wire exec = xfer && avs_write && (avs_address == `AWC_OFF_INSTR);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else if (req && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // read decode, prepared during the wait cycle
    always @* begin
        rdata_next = 32'h00000000;
        if (avs_address >= `AWC_OFF_GPR_BASE && avs_address <= `AWC_OFF_GPR_LAST
                && avs_address[1:0] == 2'b00) begin
            rdata_next = gpr_reg[avs_address[5:2]];
        end else begin
            case (avs_address)
                `AWC_OFF_PC: rdata_next = pc_reg;
                `AWC_OFF_CUR_STATUS: rdata_next = current_status_reg;
                `AWC_OFF_SAVED_STATUS: rdata_next = saved_status_reg;
                `AWC_OFF_EXEC_STATUS: rdata_next = {27'h0000000, exec_status_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            avs_readdata <= 32'h00000000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= rdata_next;
    end

    // register writes and instruction execution
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 15; i = i + 1)
                gpr_reg[i] <= `AWC_RST_WORD;
            pc_reg <= `AWC_RST_WORD;
            current_status_reg <= `AWC_RST_CUR_STATUS;
            saved_status_reg <= `AWC_RST_WORD;
            exec_status_reg <= 5'h00;
            exec_pulse <= 1'b0;
        end else begin
            exec_pulse <= exec;
            if (xfer && avs_write && !exec) begin
                if (avs_address >= `AWC_OFF_GPR_BASE && avs_address <= `AWC_OFF_GPR_LAST
                        && avs_address[1:0] == 2'b00)
                    gpr_reg[avs_address[5:2]] <= avs_writedata;
                else if (avs_address == `AWC_OFF_PC)
                    pc_reg <= avs_writedata;
                else if (avs_address == `AWC_OFF_CUR_STATUS)
                    current_status_reg <= avs_writedata;
                else if (avs_address == `AWC_OFF_SAVED_STATUS)
                    saved_status_reg <= avs_writedata;
            end
            if (exec) begin
                // no exception path; only status bits report outcome
                exec_status_reg <= 5'h00;
                exec_status_reg[`AWC_EX_DONE] <= 1'b1;
                if (!is_sum) begin
                    exec_status_reg[`AWC_EX_NOTADD] <= 1'b1;
                end else if (!passed) begin
                    exec_status_reg[`AWC_EX_CONDFAIL] <= 1'b1;
                end else begin
                    // destination write
                    if (rd_idx == 4'hF)
                        pc_reg <= result;
                    else
                        gpr_reg[rd_idx] <= result;
                    // status untouched when bit 20 clear
                    if (iw[`AWC_BIT_S] && rd_idx == 4'hF) begin
                        exec_status_reg[`AWC_EX_RESTORE] <= 1'b1;
                        // no saved register: keep status, flag it
                        if (no_saved)
                            exec_status_reg[`AWC_EX_UNPRED] <= 1'b1;
                        else
                            current_status_reg <= saved_status_reg;
                    end else if (iw[`AWC_BIT_S]) begin
                        current_status_reg[`AWC_FLAG_N] <= result[31];
                        current_status_reg[`AWC_FLAG_Z] <= (result == 32'h00000000);
                        current_status_reg[`AWC_FLAG_C] <= c_out;
                        current_status_reg[`AWC_FLAG_V] <= v_out;
                        // bits 27:0 are not assigned here and hold
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire
